// file: design/sfr_core.sv
module sfr_core #(
  parameter int unsigned PROG_W      = 12,
  parameter int unsigned MAP_PERIODS = sfr_pkg::MAP_LOW_SPEED_INTERNAL_OSC_PERIODS
) (
  // Clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  // Register port
  input  wire sfr_pkg::bus_req_type        bus_i,
  output logic [7:0]                       rdata_o,
  // ALU result path
  input  wire logic                        alu_load_i,
  input  wire logic [7:0]                  alu_result_i,
  output logic [7:0]                       acc_o,
  // Program counter
  input  wire logic [PROG_W-1:0]           pc_i,
  output logic                             pc_jump_o,
  output logic [PROG_W-1:0]                pc_target_o,
  output logic                             dummy_cycle_o,
  // Table read commands
  input  wire logic                        table_read_current_page_cur_i,
  input  wire logic                        table_read_current_page_last_i,
  input  wire logic [sfr_pkg::DADDR_W-1:0] tab_dest_i,
  output logic                             table_busy_o,
  // Program and option memory fetch
  output logic                             prog_rd_o,
  output logic [PROG_W-1:0]                prog_addr_o,
  input  wire logic [sfr_pkg::PWORD_W-1:0] prog_word_i,
  output logic                             opt_rd_o,
  output logic [sfr_pkg::OPT_ADDR_W-1:0]   opt_addr_o,
  input  wire logic [sfr_pkg::PWORD_W-1:0] opt_word_i,
  // Slow oscillator, wake event, mapping state
  input  wire logic                        low_speed_internal_osc_i,
  input  wire logic                        wake_i,
  output logic                             map_active_o
);

  localparam int unsigned AW = sfr_pkg::DADDR_W;
  localparam int unsigned CW = $clog2(MAP_PERIODS + 1);
  localparam int unsigned SECT_PAD = AW - 8;

  logic [7:0]          ptr_zero, ptr_one_low, ptr_one_sect, ptr_two_low, ptr_two_sect;
  logic [7:0]          tbl_low, tbl_high, tbl_result_hi, option_unlock;
  logic [AW-1:0]       eff_addr;
  logic                eff_indirect, eff_sfr;
  logic [7:0]          sfr_rdata;
  logic                wr_eff, rd_eff;
  logic                mem_we;
  logic [AW-1:0]       mem_waddr;
  logic [7:0]          mem_wdata;
  logic                unlock_armed, unlock_hit;
  logic [CW-1:0]       map_count;
  logic                low_speed_internal_osc_s1, low_speed_internal_osc_s2, low_speed_internal_osc_s3, low_speed_internal_osc_level, low_speed_internal_osc_rise;
  logic                opt_sel;
  logic [AW-1:0]       tab_dest;
  logic [PROG_W-1:0]   tab_addr;
  logic                tab_opt_hit;
  sfr_pkg::tbl_state_type tbl_state;

  // Write to a sector 0 special register at the resolved address
  function automatic logic sfr_write(input logic [AW-1:0] a, input logic [7:0] ofs);
    sfr_write = (a[AW-1:8] == '0) && (a[7:0] == ofs);
  endfunction

  // Resolve indirect ports to their pointers; direct addresses carry the sector
  always_comb begin
    eff_addr = bus_i.addr;                                              // [R05]
    if (bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_INDIRECT_ZERO}) begin
      eff_addr = {{SECT_PAD{1'b0}}, ptr_zero};                          // [R01] [R02]
    end else if (bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_INDIRECT_ONE}) begin
      eff_addr = {ptr_one_sect[AW-9:0], ptr_one_low};                   // [R01] [R03]
    end else if (bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_INDIRECT_TWO}) begin
      eff_addr = {ptr_two_sect[AW-9:0], ptr_two_low};                   // [R01] [R03]
    end
  end

  // Classify the resolved address and build the special register read value
  always_comb begin
    eff_indirect = sfr_write(eff_addr, sfr_pkg::OFS_INDIRECT_ZERO) ||
                   sfr_write(eff_addr, sfr_pkg::OFS_INDIRECT_ONE)  ||
                   sfr_write(eff_addr, sfr_pkg::OFS_INDIRECT_TWO);
    eff_sfr      = 1'b1;
    sfr_rdata    = sfr_pkg::INDIRECT_READ;                              // [R20]
    if (eff_addr[AW-1:8] != '0) begin
      eff_sfr = 1'b0;
    end else begin
      case (eff_addr[7:0])
        sfr_pkg::OFS_PTR_ZERO:      sfr_rdata = ptr_zero;               // [R04]
        sfr_pkg::OFS_PTR_ONE_LOW:   sfr_rdata = ptr_one_low;
        sfr_pkg::OFS_PTR_ONE_SECT:  sfr_rdata = ptr_one_sect;
        sfr_pkg::OFS_PTR_TWO_LOW:   sfr_rdata = ptr_two_low;
        sfr_pkg::OFS_PTR_TWO_SECT:  sfr_rdata = ptr_two_sect;
        sfr_pkg::OFS_ACC:           sfr_rdata = acc_o;
        sfr_pkg::OFS_PC_LOW:        sfr_rdata = pc_i[7:0];
        sfr_pkg::OFS_TBL_LOW:       sfr_rdata = tbl_low;
        sfr_pkg::OFS_TBL_RESULT_HI: sfr_rdata = tbl_result_hi;
        sfr_pkg::OFS_TBL_HIGH:      sfr_rdata = tbl_high;
        sfr_pkg::OFS_OPTION_UNLOCK: sfr_rdata = option_unlock;
        sfr_pkg::OFS_INDIRECT_ZERO,
        sfr_pkg::OFS_INDIRECT_ONE,
        sfr_pkg::OFS_INDIRECT_TWO:  sfr_rdata = sfr_pkg::INDIRECT_READ; // [R20]
        default:                    eff_sfr   = 1'b0;
      endcase
    end
    wr_eff = bus_i.wr && !eff_indirect;                                 // [R20]
    rd_eff = bus_i.rd;
  end

  // Memory write port: a table store takes priority over the register port
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = eff_addr;
    mem_wdata = bus_i.wdata;
    if (tbl_state == sfr_pkg::TBL_STORE) begin
      mem_we    = 1'b1;                                                 // [R10]
      mem_waddr = tab_dest;
      mem_wdata = opt_sel ? opt_word_i[7:0] : prog_word_i[7:0];
    end else if (wr_eff && !eff_sfr) begin
      mem_we = 1'b1;                                                    // [R01]
    end
  end

  // Shared data memory; its output flop is the read data port
  data_ram #(
    .AW(AW),
    .DW(8)
  ) u_ram (
    .clk_sys_i     (clk_sys_i),
    .resetn_i      (resetn_i),
    .we_i          (mem_we),
    .waddr_i       (mem_waddr),
    .wdata_i       (mem_wdata),
    .re_i          (rd_eff),
    .raddr_i       (eff_addr),
    .bypass_i      (eff_sfr),
    .bypass_data_i (sfr_rdata),
    .q_o           (rdata_o)
  );

  // Memory pointers behave as ordinary read/write registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_zero     <= sfr_pkg::REG_RESET;
      ptr_one_low  <= sfr_pkg::REG_RESET;
      ptr_one_sect <= sfr_pkg::REG_RESET;
      ptr_two_low  <= sfr_pkg::REG_RESET;
      ptr_two_sect <= sfr_pkg::REG_RESET;
    end else if (wr_eff) begin
      if (sfr_write(eff_addr, sfr_pkg::OFS_PTR_ZERO))     ptr_zero     <= bus_i.wdata; // [R04]
      if (sfr_write(eff_addr, sfr_pkg::OFS_PTR_ONE_LOW))  ptr_one_low  <= bus_i.wdata;
      if (sfr_write(eff_addr, sfr_pkg::OFS_PTR_ONE_SECT)) ptr_one_sect <= bus_i.wdata;
      if (sfr_write(eff_addr, sfr_pkg::OFS_PTR_TWO_LOW))  ptr_two_low  <= bus_i.wdata;
      if (sfr_write(eff_addr, sfr_pkg::OFS_PTR_TWO_SECT)) ptr_two_sect <= bus_i.wdata;
    end
  end

  // Accumulator: ALU result wins over a same-cycle register write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_o <= sfr_pkg::REG_RESET;
    end else if (alu_load_i) begin
      acc_o <= alu_result_i;                                            // [R06]
    end else if (wr_eff && sfr_write(eff_addr, sfr_pkg::OFS_ACC)) begin
      acc_o <= bus_i.wdata;
    end
  end

  // Low byte write jumps inside the current page, then one dummy cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_jump_o     <= 1'b0;
      pc_target_o   <= '0;
      dummy_cycle_o <= 1'b0;
    end else begin
      pc_jump_o     <= wr_eff && sfr_write(eff_addr, sfr_pkg::OFS_PC_LOW);  // [R07]
      dummy_cycle_o <= pc_jump_o;                                           // [R08]
      if (wr_eff && sfr_write(eff_addr, sfr_pkg::OFS_PC_LOW)) begin
        pc_target_o <= {pc_i[PROG_W-1:8], bus_i.wdata};                     // [R07]
      end
    end
  end

  // Table pointers are plain registers that software sets up first
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tbl_low  <= sfr_pkg::REG_RESET;
      tbl_high <= sfr_pkg::REG_RESET;
    end else if (wr_eff) begin
      if (sfr_write(eff_addr, sfr_pkg::OFS_TBL_LOW))  tbl_low  <= bus_i.wdata; // [R09]
      if (sfr_write(eff_addr, sfr_pkg::OFS_TBL_HIGH)) tbl_high <= bus_i.wdata; // [R09]
    end
  end

  // Table address: current page from the high pointer, or the last page
  always_comb begin
    tab_addr = table_read_current_page_last_i ? {{(PROG_W-8){1'b1}}, tbl_low}
                            : {tbl_high[PROG_W-9:0], tbl_low};          // [R16]
    tab_opt_hit = map_active_o && (&tab_addr[PROG_W-1:8]) &&
                  (tbl_low >= sfr_pkg::OPT_WIN_BASE);                   // [R13]
  end

  // Table read sequencer: fetch, then split the word in two
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tbl_state     <= sfr_pkg::TBL_IDLE;
      prog_rd_o     <= 1'b0;
      opt_rd_o      <= 1'b0;
      prog_addr_o   <= '0;
      opt_addr_o    <= '0;
      opt_sel       <= 1'b0;
      tab_dest      <= '0;
      tbl_result_hi <= sfr_pkg::REG_RESET;
      table_busy_o  <= 1'b0;
    end else begin
      case (tbl_state)
        sfr_pkg::TBL_IDLE: begin
          if (table_read_current_page_cur_i || table_read_current_page_last_i) begin
            tbl_state    <= sfr_pkg::TBL_FETCH;
            prog_rd_o    <= !tab_opt_hit;
            opt_rd_o     <= tab_opt_hit;                                // [R13]
            opt_sel      <= tab_opt_hit;
            prog_addr_o  <= tab_addr;
            opt_addr_o   <= tbl_low[sfr_pkg::OPT_ADDR_W-1:0];
            tab_dest     <= tab_dest_i;
            table_busy_o <= 1'b1;
          end
        end
        sfr_pkg::TBL_FETCH: begin
          tbl_state <= sfr_pkg::TBL_STORE;
          prog_rd_o <= 1'b0;
          opt_rd_o  <= 1'b0;
        end
        sfr_pkg::TBL_STORE: begin
          tbl_state     <= sfr_pkg::TBL_IDLE;
          table_busy_o  <= 1'b0;
          tbl_result_hi <= opt_sel ? opt_word_i[15:8] : prog_word_i[15:8]; // [R10]
        end
        default: begin
          tbl_state    <= sfr_pkg::TBL_IDLE;
          prog_rd_o    <= 1'b0;
          opt_rd_o     <= 1'b0;
          table_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Unlock register holds the last written byte; wake clears it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      option_unlock <= sfr_pkg::REG_RESET;                              // [R17]
    end else if (wake_i) begin
      option_unlock <= sfr_pkg::REG_RESET;                              // [R18]
    end else if (wr_eff && sfr_write(eff_addr, sfr_pkg::OFS_OPTION_UNLOCK)) begin
      option_unlock <= bus_i.wdata;                                     // [R17]
    end
  end

  // Pattern detect: the second byte must come in the very next cycle
  assign unlock_hit = unlock_armed && wr_eff &&
                      sfr_write(eff_addr, sfr_pkg::OFS_OPTION_UNLOCK) &&
                      (bus_i.wdata == sfr_pkg::UNLOCK_SECOND);          // [R11]

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unlock_armed <= 1'b0;
    end else begin
      // Any other cycle drops a half-written pattern
      unlock_armed <= wr_eff && sfr_write(eff_addr, sfr_pkg::OFS_OPTION_UNLOCK) &&
                      (bus_i.wdata == sfr_pkg::UNLOCK_FIRST);           // [R21]
    end
  end

  // Slow oscillator: three flops, a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_speed_internal_osc_s1    <= 1'b0;
      low_speed_internal_osc_s2    <= 1'b0;
      low_speed_internal_osc_s3    <= 1'b0;
      low_speed_internal_osc_level <= 1'b0;
    end else begin
      low_speed_internal_osc_s1 <= low_speed_internal_osc_i;
      low_speed_internal_osc_s2 <= low_speed_internal_osc_s1;
      low_speed_internal_osc_s3 <= low_speed_internal_osc_s2;
      if (low_speed_internal_osc_s2 == low_speed_internal_osc_s3) begin
        low_speed_internal_osc_level <= low_speed_internal_osc_s3;
      end
    end
  end

  assign low_speed_internal_osc_rise = (low_speed_internal_osc_s2 == low_speed_internal_osc_s3) && low_speed_internal_osc_s3 && !low_speed_internal_osc_level;

  // Mapping window: counts slow oscillator rises, each unlock restarts it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      map_active_o <= 1'b0;
      map_count    <= '0;
    end else if (unlock_hit) begin
      map_active_o <= 1'b1;                                             // [R11] [R15]
      map_count    <= '0;
    end else if (map_active_o && low_speed_internal_osc_rise) begin
      if (map_count == CW'(MAP_PERIODS - 1)) begin
        map_active_o <= 1'b0;                                           // [R14]
        map_count    <= '0;
      end else begin
        map_count <= map_count + 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence write_first_s;
    bus_i.wr && bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_OPTION_UNLOCK} &&
    bus_i.wdata == sfr_pkg::UNLOCK_FIRST;
  endsequence

  sequence write_second_s;
    bus_i.wr && bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_OPTION_UNLOCK} &&
    bus_i.wdata == sfr_pkg::UNLOCK_SECOND;
  endsequence

  indirect_write_a: assert property ( // [R01]
    bus_i.wr && bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_INDIRECT_ONE} && !eff_sfr &&
    tbl_state != sfr_pkg::TBL_STORE |-> mem_we && mem_waddr == {ptr_one_sect[AW-9:0], ptr_one_low})
    else $error("indirect write missed its pointer");
  sector_zero_a: assert property ( // [R02]
    bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_INDIRECT_ZERO} |-> eff_addr[AW-1:8] == '0)
    else $error("first pointer left sector 0");
  pc_jump_a: assert property ( // [R07]
    bus_i.wr && bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_PC_LOW}
    |=> pc_jump_o && pc_target_o[7:0] == $past(bus_i.wdata) &&
        pc_target_o[PROG_W-1:8] == $past(pc_i[PROG_W-1:8]))
    else $error("program counter jump wrong");
  dummy_cycle_a: assert property ( // [R08]
    pc_jump_o |-> !dummy_cycle_o ##1 dummy_cycle_o)
    else $error("dummy cycle missing after jump");
  unlock_ok_a: assert property ( // [R11]
    write_first_s ##1 write_second_s |=> map_active_o && map_count == '0)
    else $error("valid pattern did not open mapping");
  unlock_broken_a: assert property ( // [R21]
    (!map_active_o and write_first_s) ##1
    !(bus_i.wr && bus_i.addr == {{SECT_PAD{1'b0}}, sfr_pkg::OFS_OPTION_UNLOCK} &&
      bus_i.wdata == sfr_pkg::UNLOCK_SECOND) |=> !map_active_o)
    else $error("broken pattern opened mapping");
  map_timeout_a: assert property ( // [R14]
    map_active_o && low_speed_internal_osc_rise && !unlock_hit && map_count == CW'(MAP_PERIODS - 1) |=> !map_active_o)
    else $error("mapping outlived its window");
  indirect_zero_a: assert property ( // [R20]
    bus_i.rd && eff_indirect |=> rdata_o == sfr_pkg::INDIRECT_READ)
    else $error("indirect port read not zero");
  table_high_a: assert property ( // [R10]
    tbl_state == sfr_pkg::TBL_STORE && !opt_sel |=> tbl_result_hi == $past(prog_word_i[15:8]))
    else $error("table high byte not captured");
  wake_clear_a: assert property ( // [R18]
    wake_i |=> option_unlock == sfr_pkg::REG_RESET)
    else $error("wake left unlock register set");

endmodule // sfr_core

// file: design/sfr_pkg.sv
// What this block does
// [R01] Indirect port accesses go to pointed location
// [R02] First pointer reaches sector 0 only
// [R03] Pointer pairs: high byte sector, low offset
// [R04] Five pointers are real read/write storage
// [R05] Extended direct address: top digit picks sector
// [R06] ALU results land in accumulator
// [R07] Program counter low write jumps within page
// [R08] Such jump inserts one dummy cycle
// [R09] Software loads table pointers before table read
// [R10] Table read: high byte kept, low stored
// [R11] Unlock needs 55H then AAH
// [R12] Software writes pattern in consecutive cycles
// [R13] Mapping shows option words at C0H-FFH
// [R14] Mapping ends after four slow oscillator periods
// [R15] Each unlock restarts the mapping timer
// [R16] Software may use either table read form
// [R17] Unlock register: 8-bit, resets to zero
// [R18] Wake from low power clears unlock register
// [R19] Software masks interrupts around the pattern
// [R20] Indirect ports read 00H, ignore writes
// [R21] Broken or late pattern leaves mapping off
package sfr_pkg;

  // Data memory addressing: sector bit above an 8-bit offset
  localparam int unsigned SECT_W  = 1;
  localparam int unsigned DADDR_W = 8 + SECT_W;

  // Special register offsets in sector 0
  localparam logic [7:0] OFS_INDIRECT_ZERO = 8'h00;
  localparam logic [7:0] OFS_PTR_ZERO      = 8'h01;
  localparam logic [7:0] OFS_INDIRECT_ONE  = 8'h02;
  localparam logic [7:0] OFS_PTR_ONE_LOW   = 8'h03;
  localparam logic [7:0] OFS_PTR_ONE_SECT  = 8'h04;
  localparam logic [7:0] OFS_ACC           = 8'h05;
  localparam logic [7:0] OFS_PC_LOW        = 8'h06;
  localparam logic [7:0] OFS_TBL_LOW       = 8'h07;
  localparam logic [7:0] OFS_TBL_RESULT_HI = 8'h08;
  localparam logic [7:0] OFS_TBL_HIGH      = 8'h09;
  localparam logic [7:0] OFS_INDIRECT_TWO  = 8'h0C;
  localparam logic [7:0] OFS_PTR_TWO_LOW   = 8'h0D;
  localparam logic [7:0] OFS_PTR_TWO_SECT  = 8'h0E;
  localparam logic [7:0] OFS_OPTION_UNLOCK = 8'h2E;

  // Reset values and fixed read values
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] INDIRECT_READ = 8'h00;

  // Unlock pattern and option window
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] OPT_WIN_BASE  = 8'hC0;
  localparam int unsigned OPT_ADDR_W   = 6;
  localparam int unsigned MAP_LOW_SPEED_INTERNAL_OSC_PERIODS = 4;

  // Program word layout
  localparam int unsigned PWORD_W = 16;

  // Table read sequencer, one-hot
  typedef enum logic [2:0] {
    TBL_IDLE  = 3'b001,
    TBL_FETCH = 3'b010,
    TBL_STORE = 3'b100
  } tbl_state_type;

  // Register port request
  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [DADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } bus_req_type;

endpackage

// file: design/data_ram.sv
module data_ram #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port with bypass for values held outside the array
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  input  wire logic          bypass_i,
  input  wire logic [DW-1:0] bypass_data_i,
  output logic      [DW-1:0] q_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array write, no reset so it maps onto block storage
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read; bypass lets special registers share this output flop
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= '0;
    end else if (re_i) begin
      q_o <= bypass_i ? bypass_data_i : mem[raddr_i];
    end
  end

endmodule // data_ram

// file: testbench/tb_sfr_core.sv
module tb_sfr_core;
  timeunit 1ns;
  timeprecision 1ns;

  // Short mapping window keeps the slow-oscillator test brief
  localparam int unsigned PROG_W      = 12;
  localparam int unsigned MAP_PERIODS = 2;

  // Design inputs and outputs
  logic                        clk_sys_i;
  logic                        resetn_i;
  sfr_pkg::bus_req_type        bus_q;
  logic [7:0]                  rdata_o;
  logic                        alu_load_i;
  logic [7:0]                  alu_result_i;
  logic [7:0]                  acc_o;
  logic [PROG_W-1:0]           pc_i;
  logic                        pc_jump_o;
  logic [PROG_W-1:0]           pc_target_o;
  logic                        dummy_cycle_o;
  logic                        table_read_current_page_cur_i;
  logic                        table_read_current_page_last_i;
  logic [sfr_pkg::DADDR_W-1:0] tab_dest_i;
  logic                        table_busy_o;
  logic                        prog_rd_o;
  logic [PROG_W-1:0]           prog_addr_o;
  logic [sfr_pkg::PWORD_W-1:0] prog_word_i;
  logic                        opt_rd_o;
  logic [sfr_pkg::OPT_ADDR_W-1:0] opt_addr_o;
  logic [sfr_pkg::PWORD_W-1:0] opt_word_i;
  logic                        low_speed_internal_osc_i;
  logic                        wake_i;
  logic                        map_active_o;
  int                          failures;
  int                          tests_run;

  sfr_core #(.PROG_W(PROG_W), .MAP_PERIODS(MAP_PERIODS)) u_sfr_core (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus_q), .rdata_o(rdata_o),
    .alu_load_i(alu_load_i), .alu_result_i(alu_result_i), .acc_o(acc_o),
    .pc_i(pc_i), .pc_jump_o(pc_jump_o), .pc_target_o(pc_target_o), .dummy_cycle_o(dummy_cycle_o),
    .table_read_current_page_cur_i(table_read_current_page_cur_i), .table_read_current_page_last_i(table_read_current_page_last_i), .tab_dest_i(tab_dest_i),
    .table_busy_o(table_busy_o), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
    .prog_word_i(prog_word_i), .opt_rd_o(opt_rd_o), .opt_addr_o(opt_addr_o),
    .opt_word_i(opt_word_i), .low_speed_internal_osc_i(low_speed_internal_osc_i), .wake_i(wake_i), .map_active_o(map_active_o));

  // 10 MHz system clock
  always #50 clk_sys_i = ~clk_sys_i;

  // One compare for every kind of result, widened to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write; an idle cycle follows so strobes never collide
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    bus_q <= '0;
    @(posedge clk_sys_i);
  endtask

  // Bus read, data taken in the single cycle where it stands
  task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    bus_q <= '0;
    #1 chk({8'h00, rdata_o}, {8'h00, exp});
    @(posedge clk_sys_i);
  endtask

  // Pattern writes in consecutive cycles; interrupts assumed masked
  task automatic unlock();
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h02E, wdata: 8'h55};
    @(posedge clk_sys_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h02E, wdata: 8'hAA};
    @(posedge clk_sys_i);
    bus_q <= '0;
    #1 chk(16'(map_active_o), 16'h0001);
    @(posedge clk_sys_i);
  endtask

  // One slow oscillator period, plenty of time for the synchroniser
  task automatic low_speed_internal_osc_period();
    low_speed_internal_osc_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    low_speed_internal_osc_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic s_pointers();
    rdc(9'h02E, 8'h00);
    wr(9'h003, 8'h40);
    wr(9'h004, 8'h01);
    wr(9'h002, 8'h5A);
    rdc(9'h140, 8'h5A);
    rdc(9'h003, 8'h40);
    rdc(9'h004, 8'h01);
    wr(9'h1F0, 8'h9C);
    wr(9'h00D, 8'hF0);
    wr(9'h00E, 8'h01);
    rdc(9'h00C, 8'h9C);
    wr(9'h150, 8'h11);
    wr(9'h001, 8'h50);
    wr(9'h000, 8'h33);
    rdc(9'h050, 8'h33);
    rdc(9'h150, 8'h11);
    wr(9'h001, 8'h00);
    wr(9'h000, 8'h77);
    rdc(9'h000, 8'h00);
    rdc(9'h001, 8'h00);
  endtask

  task automatic s_acc_pc();
    alu_load_i   <= 1'b1;
    alu_result_i <= 8'h3C;
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h005, wdata: 8'h99};
    @(posedge clk_sys_i);
    alu_load_i <= 1'b0;
    bus_q      <= '0;
    #1 chk({8'h00, acc_o}, 16'h003C);
    @(posedge clk_sys_i);
    pc_i  <= 12'h3A7;
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h006, wdata: 8'h12};
    @(posedge clk_sys_i);
    bus_q <= '0;
    #1 chk({pc_jump_o, 3'b000, pc_target_o}, 16'h8312);
    @(posedge clk_sys_i);
    #1 chk({14'h0000, pc_jump_o, dummy_cycle_o}, 16'h0001);
    @(posedge clk_sys_i);
  endtask

  task automatic s_bad_unlock();
    wr(9'h02E, 8'h55);
    wr(9'h02E, 8'hAA);
    chk(16'(map_active_o), 16'h0000);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h02E, wdata: 8'h55};
    @(posedge clk_sys_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: 9'h02E, wdata: 8'h33};
    @(posedge clk_sys_i);
    bus_q <= '0;
    repeat (2) @(posedge clk_sys_i);
    chk(16'(map_active_o), 16'h0000);
    rdc(9'h02E, 8'h33);
    wake_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_i <= 1'b0;
    @(posedge clk_sys_i);
    rdc(9'h02E, 8'h00);
  endtask

  // Table read command and its three-cycle walk
  task automatic tab(input logic last, input logic opt, input logic [15:0] a, input logic [7:0] hi);
    table_read_current_page_last_i <= last;
    table_read_current_page_cur_i  <= ~last;
    @(posedge clk_sys_i);
    table_read_current_page_last_i <= 1'b0;
    table_read_current_page_cur_i  <= 1'b0;
    #1 chk({table_busy_o, prog_rd_o, opt_rd_o, 1'b0, opt ? {6'h00, opt_addr_o} : prog_addr_o},
           {1'b1, ~opt, opt, 1'b0, a[11:0]});
    repeat (2) @(posedge clk_sys_i);
    #1 chk(16'(table_busy_o), 16'h0000);
    @(posedge clk_sys_i);
    rdc(9'h008, hi);
    rdc(tab_dest_i, opt ? opt_word_i[7:0] : prog_word_i[7:0]);
  endtask

  task automatic s_map_table();
    prog_word_i <= 16'h7E21;
    opt_word_i  <= 16'hBEEF;
    tab_dest_i  <= 9'h060;
    wr(9'h007, 8'h10);
    wr(9'h009, 8'h0F);
    unlock();
    tab(1'b0, 1'b0, 16'h0F10, 8'h7E);
    wr(9'h007, 8'hC5);
    tab(1'b1, 1'b1, 16'h0005, 8'hBE);
    low_speed_internal_osc_period();
    chk(16'(map_active_o), 16'h0001);
    unlock();
    low_speed_internal_osc_period();
    chk(16'(map_active_o), 16'h0001);
    low_speed_internal_osc_period();
    chk(16'(map_active_o), 16'h0000);
    tab(1'b1, 1'b0, 16'h0FC5, 8'h7E);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk_sys_i = 1'b0; resetn_i = 1'b0; bus_q = '0; alu_load_i = 1'b0; alu_result_i = 8'h00;
    pc_i = '0; table_read_current_page_cur_i = 1'b0; table_read_current_page_last_i = 1'b0; tab_dest_i = '0; prog_word_i = '0;
    opt_word_i = '0; low_speed_internal_osc_i = 1'b0; wake_i = 1'b0; failures = 0; tests_run = 0;
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    s_pointers();
    s_acc_pc();
    s_bad_unlock();
    s_map_table();
    give_verdict();
  end

  // Hang guard, far beyond the roughly 160 cycles the tests need
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule // tb_sfr_core
